// ### verilog/flat_field_defines.svh
// Offsets, fields, reset values and overview for the flat field stage
// Overview of operation
// - Output is gain times (pixel plus offset)
// - Coefficients chosen by column, never by row
// - Enable resets on; off means plain pass-through
// - Three sources; factory is reset default
// - Factory coefficients follow camera gain level
// - User table ignores camera gain level
// - Default user table applies no correction
// - Table accesses accepted only in calibration
// - Calibration forces and locks correction off
// - Calibration edits wait for leaving calibration
// - Table addressed by column coordinate only
// - One gain and one offset per column entry
// - 16-bit offset must be step multiple
// - Reload restores saved table or defaults
// - Save replaces stored copy with table
`ifndef FLAT_FIELD_DEFINES_SVH
`define FLAT_FIELD_DEFINES_SVH
`define REG_CTRL 8'h00
`define REG_COLUMN 8'h04
`define REG_GAIN 8'h08
`define REG_OFFSET 8'h0C
`define REG_STEP 8'h10
`define REG_CMD 8'h14
`define REG_STATUS 8'h18
`define REG_IRQ_CLEAR 8'h1C
`define REG_IRQ_ENABLE 8'h20
`define REG_STATE 8'h24
`define CTRL_EN_BIT 0
`define CTRL_SRC_LSB 1
`define RST_CORRECTION_ON 1'b1
`define CMD_RELOAD_BIT 0
`define CMD_PERSIST_BIT 1
`define STAT_W 4
`define STAT_OFFSET_ERR 0
`define STAT_ACCESS_ERR 1
`define STAT_SWEEP_DONE 2
`define STAT_CMD_REFUSED 3
`define GAIN_UNITY 16'h8000
`define GAIN_FRAC 15
`define OFFSET_ZERO 16'h0000
`endif

// ### verilog/flat_field_pkg.sv
// Types shared by the flat field correction stage
package flat_field_pkg;
  typedef enum logic [1:0] {
    SRC_FACTORY = 2'b00,
    SRC_USER = 2'b01,
    SRC_CALIB = 2'b10
  } coef_src_e;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_APPLY = 2'b01,
    SW_RELOAD = 2'b10,
    SW_SAVE = 2'b11
  } sweep_state_e;
endpackage

// ### verilog/column_flat_field_correction.sv
// Column flat field correction stage with user table and register port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "flat_field_defines.svh"
module column_flat_field_correction #(
  parameter int COL_W = 6,
  parameter int PIX_W = 12,
  parameter int LEVEL_W = 2,
  parameter int OFFSET_STEP_LOG2 = 5
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic pix_valid_in,
  input wire logic [PIX_W-1:0] pix_data_in,
  input wire logic [COL_W-1:0] pix_col_in,
  input wire logic [LEVEL_W-1:0] cam_gain_level_in,
  output logic pix_valid_out,
  output logic [PIX_W-1:0] pix_data_out,
  output logic [COL_W-1:0] factory_col_out,
  output logic [LEVEL_W-1:0] factory_level_out,
  input wire logic [15:0] factory_gain_in,
  input wire logic [15:0] factory_offset_in,
  output logic irq_out
);
  import flat_field_pkg::*;

  localparam int NUM_COLS = 1 << COL_W;
  localparam int SUM_W = 18;
  localparam int PROD_W = SUM_W + 17;
  localparam [COL_W-1:0] LAST_COL = COL_W'(NUM_COLS - 1);
  localparam [PIX_W-1:0] PIX_MAX = '1;

  function automatic logic is_table_addr(input logic [7:0] a);
    return a == `REG_COLUMN || a == `REG_GAIN || a == `REG_OFFSET;
  endfunction

  logic correction_on;
  coef_src_e coefficient_source_select;
  logic [COL_W-1:0] column_index;
  logic [15:0] edit_gain [NUM_COLS];
  logic [15:0] edit_off [NUM_COLS];
  logic [15:0] act_gain [NUM_COLS];
  logic [15:0] act_off [NUM_COLS];
  logic [15:0] nv_gain [NUM_COLS];
  logic [15:0] nv_off [NUM_COLS];
  logic saved_valid;
  logic apply_pending;
  logic reload_act;
  sweep_state_e sweep_state;
  logic [COL_W-1:0] sweep_col;
  logic [`STAT_W-1:0] status;
  logic [`STAT_W-1:0] irq_enable;
  logic [`STAT_W-1:0] next_status;
  logic a_valid;
  logic [PIX_W-1:0] a_data;
  logic [15:0] a_gain;
  logic [15:0] a_off;
  logic [15:0] sel_gain;
  logic [15:0] sel_off;
  logic signed [SUM_W-1:0] sum;
  logic signed [PROD_W-1:0] prod;
  logic [PIX_W-1:0] corrected;

  wire calib = coefficient_source_select == SRC_CALIB;
  wire busy = sweep_state != SW_IDLE;
  wire wr_ctrl = wr_in && addr_in == `REG_CTRL;
  wire [1:0] wr_src = wdata_in[`CTRL_SRC_LSB +: 2];
  wire src_ok = wr_src != 2'b11;
  wire enter_cal = wr_ctrl && !calib && wr_src == SRC_CALIB;
  wire leave_cal = wr_ctrl && calib && src_ok && wr_src != SRC_CALIB;
  wire tbl_denied = (wr_in || rd_in) && is_table_addr(addr_in) && !calib;
  wire coef_wr = wr_in && calib && (addr_in == `REG_GAIN || addr_in == `REG_OFFSET);
  wire off_bad = |wdata_in[OFFSET_STEP_LOG2-1:0];
  wire wr_gain = coef_wr && !busy && addr_in == `REG_GAIN;
  wire wr_off = coef_wr && !busy && addr_in == `REG_OFFSET && !off_bad;
  wire off_err_ev = coef_wr && addr_in == `REG_OFFSET && off_bad;
  wire wr_cmd = wr_in && addr_in == `REG_CMD;
  wire cmd_reload = wr_cmd && wdata_in[`CMD_RELOAD_BIT];
  wire cmd_go = cmd_reload || (wr_cmd && wdata_in[`CMD_PERSIST_BIT]);
  wire cmd_refused = (cmd_go && (busy || apply_pending)) || (coef_wr && busy);
  wire done_ev = busy && sweep_col == LAST_COL;
  wire loading = apply_pending || sweep_state == SW_APPLY
                 || (sweep_state == SW_RELOAD && reload_act);
  // User mode bypasses while its table is still being filled
  wire use_corr = correction_on && !calib
                  && !(coefficient_source_select == SRC_USER && loading);

  // Mode and enable
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      correction_on <= `RST_CORRECTION_ON;
      coefficient_source_select <= SRC_FACTORY;
    end else if (ce_in && wr_ctrl) begin
      if (src_ok) begin
        coefficient_source_select <= coef_src_e'(wr_src);
      end
      if (enter_cal) begin
        correction_on <= 1'b0;
      end else if (!calib) begin
        correction_on <= wdata_in[`CTRL_EN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      column_index <= '0;
    end else if (ce_in && wr_in && calib && addr_in == `REG_COLUMN) begin
      column_index <= wdata_in[COL_W-1:0];
    end
  end

  // Apply request outlives a busy sweep so it is never dropped
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      apply_pending <= 1'b0;
    end else if (ce_in) begin
      if (leave_cal) begin
        apply_pending <= 1'b1;
      end else if (!busy) begin
        apply_pending <= 1'b0;
      end
    end
  end

  // Column sweep for apply, reload and save
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sweep_state <= SW_IDLE;
      sweep_col <= '0;
      reload_act <= 1'b0;
    end else if (ce_in) begin
      case (sweep_state)
        SW_IDLE: begin
          sweep_col <= '0;
          if (apply_pending) begin
            sweep_state <= SW_APPLY;
          end else if (cmd_go) begin
            sweep_state <= cmd_reload ? SW_RELOAD : SW_SAVE;
            reload_act <= !calib;
          end
        end
        SW_APPLY, SW_RELOAD, SW_SAVE: begin
          sweep_col <= sweep_col + 1'b1;
          if (sweep_col == LAST_COL) begin
            sweep_state <= SW_IDLE;
          end
        end
        default: begin
          sweep_state <= SW_IDLE;
        end
      endcase
    end
  end

  // Edited table, touched only from calibration writes and reloads
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_COLS; i++) begin
        edit_gain[i] <= `GAIN_UNITY;
        edit_off[i] <= `OFFSET_ZERO;
      end
    end else if (ce_in) begin
      if (sweep_state == SW_RELOAD) begin
        edit_gain[sweep_col] <= saved_valid ? nv_gain[sweep_col] : `GAIN_UNITY;
        edit_off[sweep_col] <= saved_valid ? nv_off[sweep_col] : `OFFSET_ZERO;
      end else begin
        if (wr_gain) begin
          edit_gain[column_index] <= wdata_in[15:0];
        end
        if (wr_off) begin
          edit_off[column_index] <= wdata_in[15:0];
        end
      end
    end
  end

  // Active table feeds the pixels; calibration edits reach it only by apply
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_COLS; i++) begin
        act_gain[i] <= `GAIN_UNITY;
        act_off[i] <= `OFFSET_ZERO;
      end
    end else if (ce_in) begin
      if (sweep_state == SW_APPLY) begin
        act_gain[sweep_col] <= edit_gain[sweep_col];
        act_off[sweep_col] <= edit_off[sweep_col];
      end else if (sweep_state == SW_RELOAD && reload_act) begin
        act_gain[sweep_col] <= saved_valid ? nv_gain[sweep_col] : `GAIN_UNITY;
        act_off[sweep_col] <= saved_valid ? nv_off[sweep_col] : `OFFSET_ZERO;
      end
    end
  end

  // Stored copy; validity flag is lost on reset, a real part keeps it
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && sweep_state == SW_SAVE) begin
      nv_gain[sweep_col] <= edit_gain[sweep_col];
      nv_off[sweep_col] <= edit_off[sweep_col];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      saved_valid <= 1'b0;
    end else if (ce_in && sweep_state == SW_SAVE && sweep_col == LAST_COL) begin
      saved_valid <= 1'b1;
    end
  end

  // Sticky status, set beats clear
  always_comb begin
    next_status = status;
    if (wr_in && addr_in == `REG_IRQ_CLEAR) begin
      next_status = status & ~wdata_in[`STAT_W-1:0];
    end
    next_status[`STAT_OFFSET_ERR] = next_status[`STAT_OFFSET_ERR] | off_err_ev;
    next_status[`STAT_ACCESS_ERR] = next_status[`STAT_ACCESS_ERR] | tbl_denied;
    next_status[`STAT_SWEEP_DONE] = next_status[`STAT_SWEEP_DONE] | done_ev;
    next_status[`STAT_CMD_REFUSED] = next_status[`STAT_CMD_REFUSED] | cmd_refused;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status <= '0;
      irq_enable <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      status <= next_status;
      if (wr_in && addr_in == `REG_IRQ_ENABLE) begin
        irq_enable <= wdata_in[`STAT_W-1:0];
      end
      irq_out <= |(next_status & irq_enable);
    end
  end

  // Read data stands for one enabled cycle only
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= '0;
      if (rd_in) begin
        case (addr_in)
          `REG_CTRL: rd_data_out <= {29'h0, coefficient_source_select, correction_on};
          `REG_COLUMN: rd_data_out <= calib ? 32'(column_index) : 32'h0;
          `REG_GAIN: rd_data_out <= calib ? {16'h0, edit_gain[column_index]} : 32'h0;
          `REG_OFFSET: rd_data_out <= calib ? {16'h0, edit_off[column_index]} : 32'h0;
          `REG_STEP: rd_data_out <= 32'h1 << OFFSET_STEP_LOG2;
          `REG_STATUS: rd_data_out <= 32'(status);
          `REG_IRQ_ENABLE: rd_data_out <= 32'(irq_enable);
          `REG_STATE: rd_data_out <= {28'h0, use_corr, saved_valid, loading, busy};
          default: rd_data_out <= 32'h0;
        endcase
      end
    end
  end

  // Stage A: column lookup and factory address
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      a_valid <= 1'b0;
      a_data <= '0;
      a_gain <= `GAIN_UNITY;
      a_off <= `OFFSET_ZERO;
      factory_col_out <= '0;
      factory_level_out <= '0;
    end else if (ce_in) begin
      a_valid <= pix_valid_in;
      a_data <= pix_data_in;
      a_gain <= act_gain[pix_col_in];
      a_off <= act_off[pix_col_in];
      factory_col_out <= pix_col_in;
      factory_level_out <= cam_gain_level_in;
    end
  end

  // Stage B: correct, round toward zero and clamp to pixel range
  always_comb begin
    sel_gain = a_gain;
    sel_off = a_off;
    if (coefficient_source_select == SRC_FACTORY) begin
      sel_gain = factory_gain_in;
      sel_off = factory_offset_in;
    end
    sum = $signed({{(SUM_W-PIX_W){1'b0}}, a_data}) + SUM_W'($signed(sel_off));
    prod = PROD_W'(sum) * $signed({{(PROD_W-16){1'b0}}, sel_gain});
    if (prod < 0) begin
      corrected = '0;
    end else if ((prod >>> `GAIN_FRAC) > PROD_W'(PIX_MAX)) begin
      corrected = PIX_MAX;
    end else begin
      corrected = prod[`GAIN_FRAC +: PIX_W];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pix_valid_out <= 1'b0;
      pix_data_out <= '0;
    end else if (ce_in) begin
      pix_valid_out <= a_valid;
      pix_data_out <= use_corr ? corrected : a_data;
    end
  end

  // Helper count for the sweep length check; frozen with the rest by ce_in
  logic [COL_W:0] busy_cnt;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_cnt <= '0;
    end else if (ce_in) begin
      if (!busy) begin
        busy_cnt <= '0;
      end else begin
        busy_cnt <= busy_cnt + 1'b1;
      end
    end
  end

  // Checks sample on the rising edge; reset masks them
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  chk_pixel_latency: assert property ((pix_valid_in && ce_in) ##1 ce_in |=> pix_valid_out)
    else $error("pixel did not emerge after two enabled cycles");
  chk_bypass_plain: assert property ((ce_in && !use_corr) |=> pix_data_out == $past(a_data))
    else $error("pixel altered while correction inactive");
  chk_calib_lock: assert property ((ce_in && wr_ctrl && (calib || wr_src == SRC_CALIB))
    |=> !correction_on)
    else $error("enable changed during calibration");
  chk_table_gated: assert property ((ce_in && rd_in && is_table_addr(addr_in) && !calib)
    |=> rd_data_out == 32'h0 && status[`STAT_ACCESS_ERR])
    else $error("table read outside calibration not refused");
  chk_offset_step: assert property ((ce_in && off_err_ev) |=> status[`STAT_OFFSET_ERR]
    && edit_off[$past(column_index)] == $past(edit_off[column_index]))
    else $error("misaligned offset accepted");
  chk_sweep_bound: assert property (busy_cnt <= (COL_W+1)'(NUM_COLS))
    else $error("table sweep overran the column count");
  chk_apply_exit: assert property ((ce_in && leave_cal) |=> apply_pending || sweep_state == SW_APPLY)
    else $error("leaving calibration did not schedule apply");
  chk_reload_default: assert property (($past(sweep_state) == SW_RELOAD && sweep_state == SW_IDLE
    && !saved_valid) |-> edit_gain[LAST_COL] == `GAIN_UNITY && edit_off[LAST_COL] == 16'h0)
    else $error("reload without saved copy left non-default entry");
  chk_save_marks: assert property (($past(sweep_state) == SW_SAVE && sweep_state == SW_IDLE)
    |-> saved_valid)
    else $error("save finished without marking stored copy");
  chk_factory_level: assert property ((ce_in && pix_valid_in)
    |=> factory_level_out == $past(cam_gain_level_in))
    else $error("factory set not tracking gain level");
  chk_cmd_reads_zero: assert property ((ce_in && rd_in && addr_in == `REG_CMD) |=> rd_data_out == 32'h0)
    else $error("command register returned state");
  // A command during a sweep must be flagged, never stacked
  chk_cmd_refused: assert property ((ce_in && cmd_go && busy) |=> status[`STAT_CMD_REFUSED])
    else $error("command during sweep not flagged");
  // Coefficient writes racing a sweep are dropped and reported
  chk_busy_write: assert property ((ce_in && coef_wr && busy) |=> status[`STAT_CMD_REFUSED])
    else $error("coefficient write during sweep not flagged");
  // Interrupt rises and falls with enabled sticky status; an enable write reaches it one cycle later
  chk_irq_level: assert property ((ce_in && |(status & irq_enable) && !(wr_in
    && (addr_in == `REG_IRQ_CLEAR || addr_in == `REG_IRQ_ENABLE))) |=> irq_out)
    else $error("interrupt low while enabled status set");

  cov_apply_run: cover property (sweep_state == SW_APPLY ##1 sweep_state == SW_APPLY);
  cov_user_correct: cover property (pix_valid_out && coefficient_source_select == SRC_USER && use_corr);
  cov_save_then_reload: cover property (sweep_state == SW_SAVE ##[1:300] sweep_state == SW_RELOAD);
  cov_offset_error: cover property (off_err_ev && ce_in);
  cov_refused_cmd: cover property (cmd_refused && ce_in);
endmodule

// ### verification/column_flat_field_correction_test.sv
// Self-checking bench for the column flat field correction stage
`timescale 1ns/1ps
`include "flat_field_defines.svh"
module column_flat_field_correction_test;
  import flat_field_pkg::*;
  localparam int COL_W = 3;
  logic sys_clk = 1'b0;
  logic resetn;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rd_data;
  logic pix_valid = 1'b0;
  logic [11:0] pix_data = 12'h000;
  logic [COL_W-1:0] pix_col = 3'h0;
  logic [1:0] level = 2'h0;
  logic valid_out;
  logic [11:0] data_out;
  logic [COL_W-1:0] fcol;
  logic [1:0] flevel;
  logic [15:0] fgain;
  logic [15:0] foffset;
  logic irq;
  logic [31:0] rv;
  int bad_count = 0;
  int compares = 0;

  always #5 sys_clk = ~sys_clk;

  // Factory store model: gain grows with level, offset with column
  assign fgain = 16'h8000 + {2'h0, flevel, 12'h000};
  assign foffset = {8'h00, fcol, 5'h00};

  column_flat_field_correction #(.COL_W(COL_W)) uut (
    .sys_clk_in(sys_clk),
    .resetn_in(resetn),
    .ce_in(ce),
    .addr_in(addr),
    .wdata_in(wdata),
    .wr_in(wr),
    .rd_in(rd),
    .rd_data_out(rd_data),
    .pix_valid_in(pix_valid),
    .pix_data_in(pix_data),
    .pix_col_in(pix_col),
    .cam_gain_level_in(level),
    .pix_valid_out(valid_out),
    .pix_data_out(data_out),
    .factory_col_out(fcol),
    .factory_level_out(flevel),
    .factory_gain_in(fgain),
    .factory_offset_in(foffset),
    .irq_out(irq)
  );

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_pix(input logic [11:0] exp);
    compares++;
    if (valid_out !== 1'b1 || data_out !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, data_out, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_rd(a, rv);
    check_word(rv, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge sys_clk);
    #1 check_word({31'h0, irq}, {31'h0, exp});
  endtask

  // Pixel out stands one edge after the one that takes it
  task automatic pix_chk(input logic [11:0] u, input logic [2:0] c, input logic [1:0] l,
                         input logic [11:0] exp);
    @(posedge sys_clk);
    pix_valid <= 1'b1;
    pix_data <= u;
    pix_col <= c;
    level <= l;
    @(posedge sys_clk);
    pix_valid <= 1'b0;
    @(posedge sys_clk);
    #1 check_pix(exp);
  endtask

  // Polls state until no sweep runs; bounded so a stuck sweep shows up
  task automatic wait_idle;
    int n;
    n = 0;
    rv = 32'h0000_0003;
    repeat (2) @(posedge sys_clk);
    while (rv[1:0] !== 2'h0 && n < 50) begin
      reg_rd(`REG_STATE, rv);
      n++;
    end
    check_word({30'h0, rv[1:0]}, 32'h0000_0000);
  endtask

  function automatic logic [11:0] fix(input int u, input int o, input int g);
    longint p;
    p = (longint'(u + o) * g) >>> 15;
    if (p < 0) p = 0;
    if (p > 4095) p = 4095;
    return p[11:0];
  endfunction

  initial begin
    #300000;
    bad_count++;
    final_report;
  end

  initial begin
    // Driven in the nonblocking region of time zero so the reset edge is seen
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    reg_chk(`REG_CTRL, 32'h0000_0001);
    reg_chk(`REG_STEP, 32'h0000_0020);
    reg_chk(8'h3C, 32'h0000_0000);
    pix_chk(12'h3E8, 3'h3, 2'h0, fix(1000, 96, 32768));
    pix_chk(12'h3E8, 3'h3, 2'h2, fix(1000, 96, 40960));
    pix_chk(12'hFA0, 3'h7, 2'h3, fix(4000, 224, 45056));
    reg_wr(`REG_COLUMN, 32'h0000_0002);
    reg_chk(`REG_COLUMN, 32'h0000_0000);
    reg_chk(`REG_STATUS, 32'h0000_0002);
    reg_wr(`REG_IRQ_CLEAR, 32'h0000_000F);
    reg_wr(`REG_CTRL, {29'h0, SRC_CALIB, 1'b1});
    reg_chk(`REG_CTRL, 32'h0000_0004);
    reg_wr(`REG_CTRL, 32'h0000_0007);
    reg_chk(`REG_CTRL, 32'h0000_0004);
    pix_chk(12'h3E8, 3'h3, 2'h0, 12'h3E8);
    reg_wr(`REG_COLUMN, 32'h0000_0002);
    reg_wr(`REG_GAIN, 32'h0000_C000);
    reg_wr(`REG_OFFSET, 32'h0000_FFC0);
    reg_wr(`REG_OFFSET, 32'h0000_0021);
    reg_chk(`REG_COLUMN, 32'h0000_0002);
    reg_chk(`REG_GAIN, 32'h0000_C000);
    reg_chk(`REG_OFFSET, 32'h0000_FFC0);
    reg_chk(`REG_STATUS, 32'h0000_0001);
    reg_wr(`REG_COLUMN, 32'h0000_0005);
    reg_chk(`REG_GAIN, 32'h0000_8000);
    reg_chk(`REG_OFFSET, 32'h0000_0000);
    pix_chk(12'h3E8, 3'h2, 2'h0, 12'h3E8);
    reg_wr(`REG_IRQ_CLEAR, 32'h0000_000F);
    reg_wr(`REG_IRQ_ENABLE, 32'h0000_0004);
    // No pixels stream while the active table loads
    reg_wr(`REG_CTRL, {29'h0, SRC_USER, 1'b1});
    wait_idle;
    reg_chk(`REG_STATUS, 32'h0000_0004);
    irq_chk(1'b1);
    // Enable bit of the leaving write is ignored; set it again
    reg_wr(`REG_CTRL, {29'h0, SRC_USER, 1'b1});
    pix_chk(12'h3E8, 3'h2, 2'h0, fix(1000, -64, 49152));
    pix_chk(12'h3E8, 3'h2, 2'h3, fix(1000, -64, 49152));
    pix_chk(12'h028, 3'h2, 2'h1, 12'h000);
    pix_chk(12'h3E8, 3'h5, 2'h2, 12'h3E8);
    reg_wr(`REG_CTRL, {29'h0, SRC_USER, 1'b0});
    pix_chk(12'h3E8, 3'h2, 2'h0, 12'h3E8);
    reg_wr(`REG_IRQ_ENABLE, 32'h0000_0000);
    irq_chk(1'b0);
    reg_wr(`REG_IRQ_ENABLE, 32'h0000_0004);
    irq_chk(1'b1);
    reg_wr(`REG_IRQ_CLEAR, 32'h0000_0004);
    irq_chk(1'b0);
    // A write while the clock enable is low must be lost
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_wr(`REG_IRQ_ENABLE, 32'h0000_0000);
    ce <= 1'b1;
    reg_chk(`REG_IRQ_ENABLE, 32'h0000_0004);
    // Reload before any save must fall back to neutral entries
    reg_wr(`REG_CTRL, {29'h0, SRC_CALIB, 1'b1});
    reg_wr(`REG_COLUMN, 32'h0000_0002);
    reg_wr(`REG_CMD, 32'h0000_0001);
    wait_idle;
    reg_chk(`REG_GAIN, 32'h0000_8000);
    reg_wr(`REG_GAIN, 32'h0000_A000);
    reg_wr(`REG_CMD, 32'h0000_0002);
    wait_idle;
    reg_chk(`REG_STATE, 32'h0000_0004);
    reg_wr(`REG_GAIN, 32'h0000_9000);
    reg_wr(`REG_CMD, 32'h0000_0001);
    wait_idle;
    reg_chk(`REG_GAIN, 32'h0000_A000);
    reg_chk(`REG_CMD, 32'h0000_0000);
    final_report;
  end
endmodule
